/* design/adcprt_conv_timer.sv */
module adcprt_conv_timer #(
   parameter int CYCLES = adcprt_pkg::CONV_CYCLES,
   parameter int CW     = adcprt_pkg::CONV_CNT_W
) (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic sys_rst,
   // Control
   input  wire logic start,
   // Status
   output logic      busy,
   output logic      done
);

   typedef struct packed {
      logic          busy;
      logic [CW-1:0] count;
   } adcprt_tmr_st_t;

   adcprt_tmr_st_t st_q;
   adcprt_tmr_st_t st_d;

   // Done fires in the last busy cycle so the latch and busy flip together
   assign busy = st_q.busy;
   assign done = st_q.busy && (st_q.count == CW'(CYCLES - 1));

   always_comb
   begin
      st_d = st_q;
      if (done)
      begin
         st_d.busy  = 1'b0;
         st_d.count = '0;
      end
      else if (st_q.busy)
      begin
         st_d.count = st_q.count + CW'(1);
      end
      else if (start)
      begin
         st_d.busy  = 1'b1;
         st_d.count = '0;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

endmodule

/* design/adcprt_pkg.sv */
package adcprt_pkg;

   // Widths of the result and of the two output groups
   localparam int RESULT_W = 12;
   localparam int LANE_W   = 8;
   localparam int UPPER_W  = 4;

   // Field positions inside the conversion result
   localparam int UPPER_LSB = 8;
   localparam int UPPER_MSB = 11;
   localparam int LOW_MSB   = 7;

   // Conversion timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int CONV_TIME_NS  = 6000;
   localparam int CONV_CYCLES   = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CONV_CNT_W    = 8;

   // Reset values
   localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;
   localparam logic [LANE_W-1:0]   LANES_RST  = 8'h00;
   localparam logic [UPPER_W-1:0]  UPPER_RST  = 4'h0;
   localparam logic                BUSY_N_RST = 1'b1;
   localparam logic                OE_N_RST   = 1'b1;

   typedef struct packed {
      logic                start_seen;
      logic [RESULT_W-1:0] result_bits;
      logic                busy_n;
      logic [LANE_W-1:0]   lanes;
      logic                lanes_oe_n;
      logic [UPPER_W-1:0]  upper;
      logic                upper_oe_n;
   } adcprt_port_st_t;

   // Byte-lane multiplexer: high select gives four zeros over the upper nibble
   function automatic logic [LANE_W-1:0] adcprt_lane_mux(input logic [RESULT_W-1:0] res,
                                                        input logic              hi_sel);
      logic [LANE_W-1:0] v;
      v = res[LOW_MSB:0];
      if (hi_sel)
      begin
         v = {4'h0, res[UPPER_MSB:UPPER_LSB]};
      end
      return v;
   endfunction

endpackage

/* design/adcprt_read_port.sv */
// Operation
// - In pipelined byte reads the first read puts the old result's low byte on the byte lanes.
// - A byte read with the upper select high drives lanes 7..4 low and new result bits 11..8 on lanes 3..0.
// - The third pipelined byte read puts the new result's low byte on the byte lanes.
// - A read with the upper select low starts a conversion and returns the low byte.
// - A read with the upper select high returns the high byte and starts nothing.
// - In wait-state use busy stays low for the whole conversion and rises with the fresh data.
// - The high-byte read of a wait-state sequence never asserts busy.
// - Each pipelined full-width read starts a conversion and returns the previous result.
// - A low-select read after a finished conversion returns the latest result and starts another.
// - A conversion starts only with chip select, read strobe and upper select all low.
// - Start conditions during a conversion are ignored until it completes.
// - While outputs are enabled the upper data pins always carry result bits 11..8.
module adcprt_read_port #(
   parameter int CONV_CYCLES = adcprt_pkg::CONV_CYCLES
) (
   // Clock and reset
   input  wire logic                              clk_sys,
   input  wire logic                              sys_rst,
   // Host strobes
   input  wire logic                              cs_n,
   input  wire logic                              rd_n,
   input  wire logic                              upper_byte_select,
   // Converter core value
   input  wire logic [adcprt_pkg::RESULT_W-1:0]   sample_value,
   // Status
   output logic                                   busy_n,
   // Shared byte lanes
   output logic [adcprt_pkg::LANE_W-1:0]          shared_byte_lanes,
   output logic                                   shared_byte_lanes_oe_n,
   // Dedicated upper data pins
   output logic [adcprt_pkg::UPPER_W-1:0]         upper_data,
   output logic                                   upper_data_oe_n
);

   adcprt_pkg::adcprt_port_st_t st_q;
   adcprt_pkg::adcprt_port_st_t st_d;

   logic read_act;
   logic start_cond;
   logic accept;
   logic tmr_busy;
   logic tmr_done;

   assign read_act   = !cs_n && !rd_n;
   assign start_cond = read_act && !upper_byte_select;
   // Edge of the start condition, so a held strobe cannot retrigger
   assign accept     = start_cond && !st_q.start_seen && !tmr_busy;

   adcprt_conv_timer #(
      .CYCLES (CONV_CYCLES),
      .CW     (adcprt_pkg::CONV_CNT_W)
   ) u_timer (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .start   (accept),
      .busy    (tmr_busy),
      .done    (tmr_done)
   );

   always_comb
   begin
      st_d            = st_q;
      st_d.start_seen = start_cond;
      // Latch the core value at the end of conversion
      if (tmr_done)
      begin
         st_d.result_bits = sample_value;
      end
      // Busy only from an accepted low-select start; high-byte reads never start
      st_d.busy_n = !(accept || (tmr_busy && !tmr_done));
      // Lanes mirror the latch as updated this cycle, so data and busy move together
      st_d.lanes      = adcprt_pkg::adcprt_lane_mux(st_d.result_bits, upper_byte_select);
      st_d.upper      = st_d.result_bits[adcprt_pkg::UPPER_MSB:adcprt_pkg::UPPER_LSB];
      st_d.lanes_oe_n = !read_act;
      st_d.upper_oe_n = !read_act;
      if (!read_act)
      begin
         st_d.lanes = adcprt_pkg::LANES_RST;
         st_d.upper = adcprt_pkg::UPPER_RST;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st_q.start_seen  <= 1'b0;
         st_q.result_bits <= adcprt_pkg::RESULT_RST;
         st_q.busy_n      <= adcprt_pkg::BUSY_N_RST;
         st_q.lanes       <= adcprt_pkg::LANES_RST;
         st_q.lanes_oe_n  <= adcprt_pkg::OE_N_RST;
         st_q.upper       <= adcprt_pkg::UPPER_RST;
         st_q.upper_oe_n  <= adcprt_pkg::OE_N_RST;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign busy_n                 = st_q.busy_n;
   assign shared_byte_lanes      = st_q.lanes;
   assign shared_byte_lanes_oe_n = st_q.lanes_oe_n;
   assign upper_data             = st_q.upper;
   assign upper_data_oe_n        = st_q.upper_oe_n;

   // Helper: length so far of the current busy period, cleared while busy is high
   logic [adcprt_pkg::CONV_CNT_W-1:0] low_cnt_q;

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         low_cnt_q <= '0;
      end
      else if (!st_q.busy_n)
      begin
         low_cnt_q <= low_cnt_q + 8'h01;
      end
      else
      begin
         low_cnt_q <= '0;
      end
   end

   sequence read_lo_s;
      !cs_n && !rd_n && !upper_byte_select;
   endsequence

   sequence read_hi_s;
      !cs_n && !rd_n && upper_byte_select;
   endsequence

   // The pins were loaded on the edge before the rise, so the read must have been open then
   sequence busy_end_s;
      $rose(st_q.busy_n) && $past(read_act);
   endsequence

   start_gate_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      accept |-> (!cs_n && !rd_n && !upper_byte_select))
      else $error("Conversion started without all three strobes low");

   start_busy_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      accept |=> !st_q.busy_n ##1 !st_q.busy_n)
      else $error("Busy did not follow an accepted start");

   no_restart_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (start_cond && tmr_busy && !tmr_done) |=> (u_timer.st_q.count == $past(u_timer.st_q.count) + 8'h01))
      else $error("Start accepted during a conversion");

   busy_length_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $rose(st_q.busy_n) |-> (low_cnt_q == 8'(CONV_CYCLES)))
      else $error("Busy period length differs from conversion time");

   fresh_data_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      busy_end_s |-> (st_q.upper == $past(sample_value[11:8])))
      else $error("Busy rose without fresh data on the pins");

   hi_nostart_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (read_hi_s and !tmr_busy) |=> st_q.busy_n)
      else $error("High-byte read asserted busy");

   hi_byte_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      read_hi_s |=> (st_q.lanes == {4'h0, st_q.result_bits[11:8]}))
      else $error("High-byte lanes wrong");

   lo_byte_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      read_lo_s |=> (st_q.lanes == st_q.result_bits[7:0]))
      else $error("Low-byte lanes wrong");

   prev_result_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      accept |=> (st_q.lanes == $past(st_q.result_bits[7:0]) && !st_q.lanes_oe_n))
      else $error("Starting read did not return the previous result");

   upper_pins_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      read_act |=> (!st_q.upper_oe_n && st_q.upper == st_q.result_bits[11:8]))
      else $error("Upper pins do not carry result bits 11..8");

   release_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !read_act |=> (st_q.lanes_oe_n && st_q.upper_oe_n))
      else $error("Pins driven without an active read");

   released_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !read_act |=> (st_q.lanes == adcprt_pkg::LANES_RST && st_q.upper == adcprt_pkg::UPPER_RST))
      else $error("Released pins do not show zero");

   oe_pair_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      st_q.lanes_oe_n == st_q.upper_oe_n)
      else $error("Upper pins and byte lanes enabled apart");

   busy_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (tmr_busy && !tmr_done) |=> !st_q.busy_n)
      else $error("Busy dropped before the conversion ended");

   busy_rise_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $rose(st_q.busy_n) |-> $past(tmr_done))
      else $error("Busy rose without a finished conversion");

   hi_held_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (read_hi_s and !tmr_busy) ##1 read_hi_s |-> st_q.busy_n)
      else $error("Held high-byte read saw busy");

   lo_start_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (read_lo_s and (!tmr_busy && !st_q.start_seen)) |=> !st_q.busy_n)
      else $error("Fresh low-byte read did not start a conversion");

   prev_upper_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      accept |=> (st_q.upper == $past(st_q.result_bits[11:8])))
      else $error("Starting read did not return the previous upper bits");

   latch_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !tmr_done |=> $stable(st_q.result_bits))
      else $error("Result latch changed outside the end of a conversion");

   timer_start_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      accept |=> tmr_busy)
      else $error("Timer did not start on an accepted start");

   timer_end_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $fell(tmr_busy) |-> $past(tmr_done))
      else $error("Timer stopped before its count ran out");

endmodule

/* tb/adcprt_host_model.sv */
module adcprt_host_model (
   // Clock
   input  wire logic clk_sys,
   // Host strobes
   output logic      cs_n,
   output logic      rd_n,
   output logic      upper_byte_select
);
   timeunit 1ns;
   timeprecision 100ps;

   // Idle with select high so a stray strobe never starts a conversion
   initial
   begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      upper_byte_select = 1'b1;
   end

   task automatic begin_read(input logic hi);
      @(posedge clk_sys);
      #1;
      upper_byte_select = hi;
      cs_n = 1'b0;
      rd_n = 1'b0;
   endtask

   task automatic end_read();
      @(posedge clk_sys);
      #1;
      cs_n = 1'b1;
      rd_n = 1'b1;
      upper_byte_select = 1'b1;
   endtask
endmodule

/* tb/adcprt_read_port_tb.sv */
module adcprt_read_port_tb;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int CONV = 10;
   logic clk_sys, sys_rst, cs_n, rd_n, upper_byte_select, busy_n, lanes_oe_n, upper_oe_n;
   logic [11:0] sample_value;
   logic [7:0]  lanes;
   logic [3:0]  upper;
   int          errors, checks_done, n;

   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   adcprt_host_model u_host (.clk_sys(clk_sys), .cs_n(cs_n), .rd_n(rd_n), .upper_byte_select(upper_byte_select));

   adcprt_read_port #(.CONV_CYCLES(CONV)) u_dut (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .cs_n(cs_n), .rd_n(rd_n),
      .upper_byte_select(upper_byte_select), .sample_value(sample_value), .busy_n(busy_n),
      .shared_byte_lanes(lanes), .shared_byte_lanes_oe_n(lanes_oe_n),
      .upper_data(upper), .upper_data_oe_n(upper_oe_n));

   task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
      checks_done++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Open a read and look at the outputs one cycle after it is taken
   task automatic read_open(input logic hi);
      u_host.begin_read(hi);
      repeat (2) @(posedge clk_sys);
      #2;
   endtask

   // Bounded wait; a stuck busy shows up as a wrong count
   task automatic wait_done(input int base);
      n = base;
      while (busy_n !== 1'b1 && n < 4 * CONV)
      begin
         @(posedge clk_sys);
         #2;
         n++;
      end
      chk("busy length", 12'(CONV), 12'(n));
   endtask

   task automatic t_wait_state();
      sample_value = 12'hA5C;
      read_open(1'b0);
      chk("busy start", 12'h000, 12'(busy_n));
      wait_done(1);
      chk("low byte", 12'h05C, 12'(lanes));
      chk("upper pins", 12'h00A, 12'(upper));
      u_host.end_read();
      read_open(1'b1);
      chk("high busy", 12'h001, 12'(busy_n));
      chk("high byte", 12'h00A, 12'(lanes));
      u_host.end_read();
      @(posedge clk_sys);
      #2;
      chk("release", 12'h003, 12'({lanes_oe_n, upper_oe_n}));
      $display("Test wait_state done");
   endtask

   task automatic t_pipelined();
      sample_value = 12'h3E7;
      read_open(1'b0);
      chk("old low", 12'h05C, 12'(lanes));
      chk("drivers on", 12'h000, 12'({lanes_oe_n, upper_oe_n}));
      chk("start", 12'h000, 12'(busy_n));
      u_host.end_read();
      wait_done(2);
      read_open(1'b1);
      chk("new high", 12'h003, 12'(lanes));
      chk("high upper", 12'h003, 12'(upper));
      chk("no start", 12'h001, 12'(busy_n));
      u_host.end_read();
      read_open(1'b0);
      chk("new low", 12'h0E7, 12'(lanes));
      chk("restart", 12'h000, 12'(busy_n));
      u_host.end_read();
      wait_done(2);
      $display("Test pipelined done");
   endtask

   task automatic t_retrigger();
      sample_value = 12'h6C1;
      read_open(1'b0);
      u_host.end_read();
      u_host.begin_read(1'b0);
      wait_done(3);
      chk("full word", 12'h6C1, {upper, lanes});
      repeat (3) @(posedge clk_sys);
      #2;
      chk("held strobe", 12'h001, 12'(busy_n));
      u_host.end_read();
      $display("Test retrigger done");
   endtask

   // Reset during a conversion must drop busy, release the pins and clear the latch
   task automatic t_reset();
      read_open(1'b0);
      @(posedge clk_sys);
      #1;
      sys_rst = 1'b1;
      @(posedge clk_sys);
      #2;
      chk("reset busy", 12'h001, 12'(busy_n));
      chk("reset release", 12'h003, 12'({lanes_oe_n, upper_oe_n}));
      chk("reset pins", 12'h000, {upper, lanes});
      u_host.end_read();
      @(posedge clk_sys);
      #1;
      sys_rst = 1'b0;
      read_open(1'b0);
      chk("cleared word", 12'h000, {upper, lanes});
      chk("start after reset", 12'h000, 12'(busy_n));
      u_host.end_read();
      wait_done(2);
      $display("Test reset done");
   endtask

   initial
   begin
      errors = 0;
      checks_done = 0;
      sys_rst = 1'b1;
      sample_value = 12'h000;
      repeat (16) @(posedge clk_sys);
      #1;
      sys_rst = 1'b0;
      t_wait_state();
      t_pipelined();
      t_retrigger();
      t_reset();
      stop_test();
   end

   // About a hundred cycles are needed; each wait is capped at four conversions
   initial
   begin
      repeat (40 * CONV + 200) @(posedge clk_sys);
      errors++;
      stop_test();
   end
endmodule
